/* osw_clock_switch.v */
// oscillator start-up counter and glitch-free system clock switcher
`timescale 1ns/1ps
`include "osw_defines.vh"

// Function
// - start-up counting only applies in low-power, standard or high-speed crystal modes
// - external oscillator is stable only after 1024 cycles on its input
// - program counter held while counting and primary oscillator is system clock
// - counting restarts on power-on, brown-out, wake, enable or power-up timer expiry
// - system clock stays on old source until the requested source is ready
// - after new source ready, wait two consecutive old-clock rising edges
// - then hold system clock low from the next old-clock falling edge
// - while held low, wait two more rising edges of the new clock
// - on next new-clock falling edge release hold and run from new clock
module osw_clock_switch #(
  parameter STARTUP_CYCLES = `OSW_STARTUP_CYCLES,
  parameter CNT_W = `OSW_STARTUP_CNT_W
) (
  input wire core_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [`OSW_MODE_W-1:0] osc_mode,
  input wire [`OSW_SEL_W-1:0] clock_source_select,
  input wire external_oscillator_input,
  input wire sec_osc_in,
  input wire int_osc_in,
  input wire sec_ready_in,
  input wire power_on_reset_event,
  input wire brown_out_reset_event,
  input wire wake_event,
  input wire osc_enable_event,
  input wire power_up_timer_expired,
  output wire sys_clk_out,
  output wire pc_hold,
  output wire startup_running,
  output wire switch_busy,
  output wire [`OSW_SEL_W-1:0] active_source
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT_READY = 3'h1;
  localparam [2:0] ST_OLD_RISE = 3'h2;
  localparam [2:0] ST_OLD_FALL = 3'h3;
  localparam [2:0] ST_NEW_RISE = 3'h4;
  localparam [2:0] ST_NEW_FALL = 3'h5;

  // full-width terminal counts, cut to the counter widths on purpose
  localparam [31:0] CNT_LAST_FULL = STARTUP_CYCLES - 1;
  localparam [31:0] EDGE_LAST_FULL = `OSW_SWITCH_EDGES - 1;
  localparam [CNT_W-1:0] CNT_LAST = CNT_LAST_FULL[CNT_W-1:0];
  localparam [1:0] EDGE_LAST = EDGE_LAST_FULL[1:0];

  // pick one bit of a per-source vector; code 3 aliases the internal source
  function pick;
    input [3:0] vec;
    input [1:0] sel;
    begin
      if (sel == 2'h3) begin
        pick = vec[`OSW_SEL_INTERNAL];
      end else begin
        pick = vec[sel];
      end
    end
  endfunction

  wire [3:0] pin_raw;
  wire [3:0] pin_sync;
  wire [3:0] lvl;
  wire [3:0] rise;
  wire [3:0] fall;
  wire [3:0] ready;
  wire crystal_mode;
  wire restart;
  wire ext_ready;

  reg [3:0] lvl_d_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg running_reg;
  reg running_next;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] cur_reg;
  reg [1:0] cur_next;
  reg [1:0] req_reg;
  reg [1:0] req_next;
  reg [1:0] edge_reg;
  reg [1:0] edge_next;
  reg hold_reg;
  reg hold_next;
  reg sys_clk_reg;
  reg pc_hold_reg;
  reg pc_hold_next;

  assign pin_raw = {sec_ready_in, int_osc_in, sec_osc_in, external_oscillator_input};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      osw_sync u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .async_in(pin_raw[gi]),
        .sync_out(pin_sync[gi])
      );
    end
  endgenerate

  // per-source clock levels; slot 3 mirrors the internal source
  assign lvl = {pin_sync[2], pin_sync[2:0]};
  assign rise = lvl & ~lvl_d_reg;
  assign fall = ~lvl & lvl_d_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_d_reg <= 4'h0;
    end else if (clk_en) begin
      lvl_d_reg <= lvl;
    end
  end

  // start-up counter on the primary oscillator
  assign crystal_mode = (osc_mode == `OSW_MODE_LOW_POWER_CRYSTAL) ||
                        (osc_mode == `OSW_MODE_STANDARD_CRYSTAL) ||
                        (osc_mode == `OSW_MODE_HIGH_SPEED_CRYSTAL);
  assign restart = crystal_mode & (power_on_reset_event | brown_out_reset_event |
                   wake_event | osc_enable_event | power_up_timer_expired);
  assign ext_ready = ~crystal_mode | ~running_reg;

  always @* begin
    cnt_next = cnt_reg;
    running_next = running_reg;
    if (restart) begin
      cnt_next = {CNT_W{1'b0}};
      running_next = 1'b1;
    end else if (running_reg && rise[`OSW_SEL_PRIMARY]) begin
      if (cnt_reg == CNT_LAST) begin
        cnt_next = {CNT_W{1'b0}};
        running_next = 1'b0;
      end else begin
        cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // secondary readiness arrives through a synchroniser; internal is always ready
  assign ready = {1'b1, 1'b1, pin_sync[3], ext_ready};

  // switch sequencer
  always @* begin
    state_next = state_reg;
    cur_next = cur_reg;
    req_next = req_reg;
    edge_next = edge_reg;
    hold_next = hold_reg;
    case (state_reg)
      ST_IDLE: begin
        if (clock_source_select != cur_reg) begin
          req_next = clock_source_select;
          state_next = ST_WAIT_READY;
        end
      end
      ST_WAIT_READY: begin
        // a new write retargets the request while nothing is committed yet
        req_next = clock_source_select;
        if (clock_source_select == cur_reg) begin
          state_next = ST_IDLE;
        end else if (pick(ready, clock_source_select)) begin
          edge_next = 2'h0;
          state_next = ST_OLD_RISE;
        end
      end
      ST_OLD_RISE: begin
        if (pick(rise, cur_reg)) begin
          if (edge_reg == EDGE_LAST) begin
            state_next = ST_OLD_FALL;
          end else begin
            edge_next = edge_reg + 2'h1;
          end
        end
      end
      ST_OLD_FALL: begin
        if (pick(fall, cur_reg)) begin
          hold_next = 1'b1;
          edge_next = 2'h0;
          state_next = ST_NEW_RISE;
        end
      end
      ST_NEW_RISE: begin
        if (pick(rise, req_reg)) begin
          if (edge_reg == EDGE_LAST) begin
            state_next = ST_NEW_FALL;
          end else begin
            edge_next = edge_reg + 2'h1;
          end
        end
      end
      ST_NEW_FALL: begin
        if (pick(fall, req_reg)) begin
          hold_next = 1'b0;
          cur_next = req_reg;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        hold_next = 1'b0;
      end
    endcase
  end

  // execution stalls while the running primary source is still starting up
  always @* begin
    pc_hold_next = running_next & crystal_mode & (cur_next == `OSW_SEL_PRIMARY);
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= {CNT_W{1'b0}};
      running_reg <= 1'b1;
      state_reg <= ST_IDLE;
      cur_reg <= `OSW_SEL_RESET;
      req_reg <= `OSW_SEL_RESET;
      edge_reg <= 2'h0;
      hold_reg <= 1'b0;
      sys_clk_reg <= 1'b0;
      pc_hold_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      running_reg <= running_next;
      state_reg <= state_next;
      cur_reg <= cur_next;
      req_reg <= req_next;
      edge_reg <= edge_next;
      hold_reg <= hold_next;
      // the old source keeps driving until the hold takes over
      sys_clk_reg <= hold_next ? 1'b0 : pick(lvl, cur_next);
      pc_hold_reg <= pc_hold_next;
    end
  end

  assign sys_clk_out = sys_clk_reg;
  assign pc_hold = pc_hold_reg;
  assign startup_running = running_reg & crystal_mode;
  assign switch_busy = (state_reg != ST_IDLE);
  assign active_source = cur_reg;

endmodule

/* osw_clock_switch_assertions.sv */
// port assertions for the start-up counter and clock switcher
`timescale 1ns/1ps
module osw_clock_switch_assertions (
  input wire core_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [2:0] osc_mode,
  input wire [1:0] clock_source_select,
  input wire power_on_reset_event,
  input wire sys_clk_out,
  input wire pc_hold,
  input wire startup_running,
  input wire switch_busy,
  input wire [1:0] active_source
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  mode_gate_a: assert property (osc_mode > 3'h2 |-> !startup_running)
    else $error("start-up count outside crystal mode");
  restart_count_a: assert property (clk_en && power_on_reset_event && osc_mode < 3'h3
    |=> startup_running) else $error("restart event did not start count");
  pc_hold_a: assert property (pc_hold && $stable(osc_mode) |-> startup_running &&
    active_source == 2'h0) else $error("program counter held wrongly");
  busy_start_a: assert property (!switch_busy && clk_en && clock_source_select < 2'h3
    && clock_source_select != active_source |=> switch_busy) else $error("switch not taken");
  wait_ready_a: assert property (switch_busy && clock_source_select == 2'h0 &&
    startup_running |=> $stable(active_source)) else $error("switched to unready source");
  quiet_low_a: assert property ($fell(switch_busy) && $changed(active_source)
    |-> !$past(sys_clk_out) &&
    !$past(sys_clk_out, 2)) else $error("system clock not held low");
  switch_bound_a: assert property ($rose(switch_busy) && clock_source_select == 2'h2
    |-> ##[4:300] !switch_busy) else $error("switch to internal too slow");
  source_move_a: assert property ($changed(active_source) |-> $fell(switch_busy))
    else $error("source changed outside switch end");
endmodule

/* osw_clock_switch_tb.sv */
// self-checking bench for the start-up counter and clock switcher
`timescale 1ns/1ps
module osw_clock_switch_tb;
  reg core_clk = 1'b0;
  reg rst_b = 1'b0;
  reg clk_en = 1'b0;
  reg [2:0] osc_mode = 3'h0;
  reg [1:0] sel = 2'h0;
  reg [4:0] ev = 5'h00;
  reg pri_run = 1'b0;
  reg sec_go = 1'b0;
  wire pri_pin, sec_pin, int_pin, sec_rdy, sys_clk, pc_hold, running, busy;
  wire [1:0] act;
  integer fails = 0;
  integer samples_checked = 0;
  integer rises = 0;
  integer sys_rises = 0;
  integer n;
  always #20 core_clk = ~core_clk;
  always @(posedge pri_pin) rises = rises + 1;
  always @(posedge sys_clk) sys_rises = sys_rises + 1;
  osw_osc_model i_osc (.pri_run(pri_run), .sec_go(sec_go), .pri_pin(pri_pin),
    .sec_pin(sec_pin), .int_pin(int_pin), .sec_rdy(sec_rdy));
  osw_clock_switch #(.STARTUP_CYCLES(8), .CNT_W(4)) i_dut (.core_clk(core_clk),
    .rst_b(rst_b), .clk_en(clk_en), .osc_mode(osc_mode), .clock_source_select(sel),
    .external_oscillator_input(pri_pin), .sec_osc_in(sec_pin), .int_osc_in(int_pin),
    .sec_ready_in(sec_rdy), .power_on_reset_event(ev[0]), .brown_out_reset_event(ev[1]),
    .wake_event(ev[2]), .osc_enable_event(ev[3]), .power_up_timer_expired(ev[4]),
    .sys_clk_out(sys_clk), .pc_hold(pc_hold), .startup_running(running),
    .switch_busy(busy), .active_source(act));
  task step(input integer k);
    begin
      repeat (k) @(posedge core_clk);
      #1;
    end
  endtask
  task chk(input string name, input [10:0] exp, input [10:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error %0s expected %0h seen %0h", name, exp, got);
      end
    end
  endtask
  task pulse(input [4:0] v);
    begin
      @(posedge core_clk);
      ev <= v;
      @(posedge core_clk);
      ev <= 5'h00;
      step(1);
    end
  endtask
  task wait_idle;
    begin
      step(2);
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
        step(1);
        n = n + 1;
      end
      if (n >= 2000) fails = fails + 1;
    end
  endtask
  task wait_run;
    begin
      n = 0;
      while (running !== 1'b0 && n < 500) begin
        step(1);
        n = n + 1;
      end
      if (n >= 500) fails = fails + 1;
    end
  endtask
  task t_startup;
    integer i;
    begin
      step(2);
      chk("pc_hold", 11'h1, pc_hold);
      rises = 0;
      pri_run <= 1'b1;
      wait_run;
      chk("rises", 11'h8, rises[10:0]);
      chk("pc_hold", 11'h0, pc_hold);
      // each event must re-arm a finished count
      for (i = 0; i < 5; i = i + 1) begin
        pulse(5'h01 << i);
        chk("running", 11'h1, running);
        chk("pc_hold", 11'h1, pc_hold);
        wait_run;
        chk("pc_hold", 11'h0, pc_hold);
      end
      $display("startup test done");
    end
  endtask
  task t_mode;
    begin
      @(posedge core_clk);
      osc_mode <= 3'h3;
      pulse(5'h1f);
      chk("running", 11'h0, running);
      @(posedge core_clk);
      osc_mode <= 3'h2;
      step(2);
      chk("running", 11'h0, running);
      $display("mode test done");
    end
  endtask
  task t_switch;
    begin
      @(posedge core_clk);
      sel <= 2'h2;
      wait_idle;
      chk("source", 11'h2, act);
      // internal source has a 5-cycle period, so 40 cycles hold 8 rises
      sys_rises = 0;
      step(40);
      chk("sys_clk_rises", 11'h8, sys_rises[10:0]);
      @(posedge core_clk);
      sel <= 2'h1;
      step(60);
      chk("source", 11'h2, act);
      chk("busy", 11'h1, busy);
      // going back to the active source before the new one is ready cancels
      @(posedge core_clk);
      sel <= 2'h2;
      step(2);
      chk("busy", 11'h0, busy);
      chk("source", 11'h2, act);
      @(posedge core_clk);
      sel <= 2'h1;
      @(posedge core_clk);
      sec_go <= 1'b1;
      wait_idle;
      chk("source", 11'h1, act);
      pulse(5'h02);
      @(posedge core_clk);
      sel <= 2'h0;
      step(3);
      chk("pc_hold", 11'h0, pc_hold);
      chk("source", 11'h1, act);
      wait_idle;
      chk("source", 11'h0, act);
      chk("running", 11'h0, running);
      $display("switch test done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    clk_en <= 1'b1;
    t_startup;
    t_mode;
    t_switch;
    end_sim;
  end
  initial begin
    repeat (8000) @(posedge core_clk);
    fails = fails + 1;
    end_sim;
  end
endmodule
bind osw_clock_switch osw_clock_switch_assertions i_chk (.core_clk(core_clk), .rst_b(rst_b),
  .clk_en(clk_en), .osc_mode(osc_mode), .clock_source_select(clock_source_select),
  .power_on_reset_event(power_on_reset_event), .sys_clk_out(sys_clk_out),
  .pc_hold(pc_hold), .startup_running(startup_running), .switch_busy(switch_busy),
  .active_source(active_source));

/* osw_defines.vh */
// constants for the oscillator start-up counter and clock switcher
`ifndef OSW_DEFINES_VH
`define OSW_DEFINES_VH

// oscillator mode configuration codes
`define OSW_MODE_W 3
`define OSW_MODE_LOW_POWER_CRYSTAL 3'h0
`define OSW_MODE_STANDARD_CRYSTAL 3'h1
`define OSW_MODE_HIGH_SPEED_CRYSTAL 3'h2
`define OSW_MODE_EXT_CLOCK 3'h3

// clock source select codes
`define OSW_SEL_W 2
`define OSW_SEL_PRIMARY 2'h0
`define OSW_SEL_SECONDARY 2'h1
`define OSW_SEL_INTERNAL 2'h2
`define OSW_SEL_RESET 2'h0

// start-up counter length in oscillator cycles, and counter width
`define OSW_STARTUP_CYCLES 1024
`define OSW_STARTUP_CNT_W 11

// edges waited on each side of the switch
`define OSW_SWITCH_EDGES 2

`endif

/* osw_osc_model.sv */
// oscillator sources and secondary ready flag seen by the switcher
`timescale 1ns/1ps
module osw_osc_model (
  input wire pri_run,
  input wire sec_go,
  output reg pri_pin,
  output reg sec_pin,
  output reg int_pin,
  output reg sec_rdy
);
  initial {pri_pin, sec_pin, int_pin, sec_rdy} = 4'h0;
  // crystal stands still until started
  always #120 if (pri_run) pri_pin = ~pri_pin;
  // offsets keep source edges away from the core clock's rising edge
  initial #5 forever #210 sec_pin = ~sec_pin;
  initial #10 forever #100 int_pin = ~int_pin;
  // slow secondary settling
  always @(sec_go) sec_rdy <= #2000 sec_go;
endmodule

/* osw_sync.v */
// two-flop synchroniser for one level from outside the core clock domain
`timescale 1ns/1ps
module osw_sync (
  input wire core_clk,
  input wire rst_b,
  input wire clk_en,
  input wire async_in,
  output wire sync_out
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
